//--- src/dac_ref_cfg.svh
/*
 * Constants for the reference ladder control registers.
 * Assumes inclusion by bare name from the package and the design module.
 */
// Operation
// - Enable bit seven switches converter on/off
// - Bit six keeps upper or lower source
// - Bit five routes level to output pin
// - Positive select 00 rail, 01 external, 10 fixed
// - Five-bit level code in second register
// - Output equals lower plus span times code/32
// - Unused bits read zero, writes ignored
// - All fields reset to zero on reset
// - Reset disables converter, pin, clears code
// - Pin overridden while output, reads zero
`ifndef DAC_REF_CFG_SVH
`define DAC_REF_CFG_SVH

// ----------------------------------------------------------------
// Register indices and fields
// ----------------------------------------------------------------
`define ADDR_W          4
`define OFS_CONTROL     4'h0
`define OFS_LEVEL       4'h1
`define BIT_ON          7
`define BIT_LPS         6
`define BIT_OE          5
`define PSS_HI          3
`define PSS_LO          2
`define BIT_NSS         0
`define LVL_HI          4
`define CTRL_WMASK      8'hED
`define LVL_WMASK       8'h1F
`define CTRL_RESET      8'h00
`define LVL_RESET       8'h00
`define PSS_RAIL        2'h0
`define PSS_EXT         2'h1
`define PSS_FIXED       2'h2
`define PSS_RSVD        2'h3
`define LVL_STEPS       6'h20
`define LVL_FULL        5'h1F
`define RD_IDLE         8'h00

`endif

//--- src/dac_ref_pkg.sv
/*
 * Types for the reference ladder control registers.
 * Assumes the constants header is on the include path.
 */
package dac_ref_pkg;
	`include "dac_ref_cfg.svh"

	// ----------------------------------------------------------------
	// Positive source choices
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_RAIL  = `PSS_RAIL,
		SRC_EXT   = `PSS_EXT,
		SRC_FIXED = `PSS_FIXED,
		SRC_RSVD  = `PSS_RSVD
	} pos_src_t;

	// Bus-visible control layout, bit 7 down to 0
	typedef struct packed {
		logic     converter_on;
		logic     low_power_source_pick;
		logic     pin_output_enable;
		logic     unused4;
		pos_src_t positive_source_select;
		logic     unused1;
		logic     negative_source_select;
	} ctrl_t;

	// Drive to the analog side
	typedef struct packed {
		logic       converter_on;
		logic       upper_source_on;  // Ladder top connected
		logic       lower_source_on;  // Ladder bottom connected
		logic       sel_rail;
		logic       sel_ext;
		logic       sel_fixed;
		logic       negative_source_select;
		logic [4:0] level_code;
	} analog_t;
endpackage

//--- src/dac_ref_regs.sv
/*
 * Control register bank for the 32-level ladder reference.
 * Assumes a simple strobe bus master on clk_sys and an analog ladder,
 * source multiplexers and pad driver outside this block.
 */
`timescale 1ns/100ps
`default_nettype none

`include "dac_ref_cfg.svh"

module dac_ref_regs
	import dac_ref_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic [`ADDR_W-1:0] addr,
	input  wire logic [7:0]         wdata,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output var  logic [7:0]         rdata,
	output var  analog_t            analog,
	output var  logic               pin_analog_mode,
	output var  logic               pin_dig_in_gated,
	input  wire logic               pin_dig_in,
	output var  logic [5:0]         level_num
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Keep only implemented bits of a write
	function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
		masked = d & m;
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_r, ctrl_nxt;  // Control byte
	logic [7:0] lvl_r, lvl_nxt;    // Level byte
	logic [7:0] rdata_r, rdata_nxt;// Read answer
	ctrl_t      c;                 // Field view

	assign c = ctrl_t'(ctrl_r);

	// Next values from writes and reads
	always_comb begin
		ctrl_nxt  = ctrl_r;
		lvl_nxt   = lvl_r;
		rdata_nxt = 8'h00;
		if (wr_stb) begin
			// Unused positions masked away on write
			if (addr == `OFS_CONTROL) begin
				ctrl_nxt = masked(wdata, `CTRL_WMASK);
			end
			if (addr == `OFS_LEVEL) begin
				lvl_nxt = masked(wdata, `LVL_WMASK);
			end
		end
		if (rd_stb) begin
			// Unmapped addresses answer zero
			case (addr)
				`OFS_CONTROL: rdata_nxt = masked(ctrl_r, `CTRL_WMASK);
				`OFS_LEVEL:   rdata_nxt = masked(lvl_r, `LVL_WMASK);
				default:      rdata_nxt = 8'h00;
			endcase
		end
	end

	// Registers; every field cleared on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_r  <= `CTRL_RESET;
			lvl_r   <= `LVL_RESET;
			rdata_r <= 8'h00;
		end else begin
			ctrl_r  <= ctrl_nxt;
			lvl_r   <= lvl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

	// ----------------------------------------------------------------
	// Analog drive, decoded from registered fields
	// ----------------------------------------------------------------
	// Code 11 is left to software; it selects nothing here
	always_comb begin
		analog.converter_on           = c.converter_on;
		analog.upper_source_on        = c.converter_on | c.low_power_source_pick;
		analog.lower_source_on        = c.converter_on | ~c.low_power_source_pick;
		analog.sel_rail  = (c.positive_source_select == SRC_RAIL);
		analog.sel_ext   = (c.positive_source_select == SRC_EXT);
		analog.sel_fixed = (c.positive_source_select == SRC_FIXED);
		analog.negative_source_select = c.negative_source_select;
		analog.level_code             = lvl_r[`LVL_HI:0];
	end

	// Tap numerator over 32 steps: out = lo + (hi-lo)*level_num/32
	assign level_num = {1'b0, lvl_r[`LVL_HI:0]};

	// Pad taken over by the analog level
	assign pin_analog_mode  = c.pin_output_enable;
	assign pin_dig_in_gated = pin_dig_in & ~c.pin_output_enable;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Bus request shapes reused by the properties below
	sequence wr_ctrl_s;
		wr_stb && addr == `OFS_CONTROL;
	endsequence
	sequence wr_lvl_s;
		wr_stb && addr == `OFS_LEVEL;
	endsequence
	sequence wr_other_s;
		wr_stb && addr != `OFS_CONTROL && addr != `OFS_LEVEL;
	endsequence
	sequence rd_ctrl_s;
		rd_stb && addr == `OFS_CONTROL;
	endsequence
	sequence rd_lvl_s;
		rd_stb && addr == `OFS_LEVEL;
	endsequence
	sequence rd_other_s;
		rd_stb && addr != `OFS_CONTROL && addr != `OFS_LEVEL;
	endsequence

	// ----------------------------------------------------------------
	// Reset behaviour
	// ----------------------------------------------------------------
	// Both bytes cleared one edge after reset
	reset_clear_a: assert property (
		@(posedge clk_sys)
		rst |=> ctrl_r == `CTRL_RESET && lvl_r == `LVL_RESET)
		else $error("reset did not clear");
	// Converter off, pad released and code cleared
	reset_off_a: assert property (
		@(posedge clk_sys)
		rst |=> !analog.converter_on && !pin_analog_mode && analog.level_code == 5'h00)
		else $error("reset left converter on");
	// No stale read answer survives reset
	reset_rdata_a: assert property (
		@(posedge clk_sys)
		rst |=> rdata == `RD_IDLE)
		else $error("reset left read data");

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	// Enable follows the written bit
	enable_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_ctrl_s |=> analog.converter_on == $past(wdata[`BIT_ON]))
		else $error("enable not written");
	// Control byte holds without a write to it
	ctrl_hold_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(wr_stb && addr == `OFS_CONTROL) |=> $stable(ctrl_r))
		else $error("control changed unasked");
	// Converter off keeps only the picked end
	low_power_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!analog.converter_on |-> analog.upper_source_on == ctrl_r[`BIT_LPS]
			&& analog.lower_source_on == !ctrl_r[`BIT_LPS])
		else $error("low power source wrong");
	// Converter on needs both ladder ends
	both_ends_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		analog.converter_on |-> analog.upper_source_on && analog.lower_source_on)
		else $error("ladder end left open");
	// Pin routing follows the written bit
	pin_route_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_ctrl_s |=> pin_analog_mode == $past(wdata[`BIT_OE]))
		else $error("pin enable not written");
	// Pad mode always mirrors the stored bit
	pin_mode_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		pin_analog_mode == ctrl_r[`BIT_OE])
		else $error("pad mode differs from bit");
	// Negative select follows the written bit
	neg_select_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_ctrl_s |=> analog.negative_source_select == $past(wdata[`BIT_NSS]))
		else $error("negative select not written");

	// ----------------------------------------------------------------
	// Positive source decode
	// ----------------------------------------------------------------
	// External reference code
	pos_decode_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		(wr_ctrl_s and (wdata[`PSS_HI:`PSS_LO] == `PSS_EXT)) |=> analog.sel_ext && !analog.sel_rail)
		else $error("positive select decode");
	// Supply rail code
	rail_decode_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		(wr_ctrl_s and (wdata[`PSS_HI:`PSS_LO] == `PSS_RAIL)) |=> analog.sel_rail && !analog.sel_fixed)
		else $error("rail select decode");
	// Fixed reference buffer code
	fixed_decode_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		(wr_ctrl_s and (wdata[`PSS_HI:`PSS_LO] == `PSS_FIXED)) |=> analog.sel_fixed && !analog.sel_ext)
		else $error("fixed select decode");
	// Never two sources on the ladder top at once
	one_hot_sel_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		$onehot0({analog.sel_rail, analog.sel_ext, analog.sel_fixed}))
		else $error("two positive sources");
	// Reserved code connects nothing
	rsvd_none_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		ctrl_r[`PSS_HI:`PSS_LO] == `PSS_RSVD |-> !analog.sel_rail && !analog.sel_ext && !analog.sel_fixed)
		else $error("reserved code selected source");

	// ----------------------------------------------------------------
	// Level code
	// ----------------------------------------------------------------
	// Level follows the written code
	level_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_lvl_s |=> analog.level_code == $past(wdata[`LVL_HI:0]))
		else $error("level code not written");
	// Level byte holds without a write to it
	level_hold_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(wr_stb && addr == `OFS_LEVEL) |=> $stable(lvl_r))
		else $error("level changed unasked");
	// Numerator stays below the step count
	level_num_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		level_num < `LVL_STEPS)
		else $error("tap numerator too large");
	// Numerator is the tap the ladder gets
	level_span_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		level_num[`LVL_HI:0] == analog.level_code && !level_num[`LVL_HI+1])
		else $error("tap numerator differs");

	// ----------------------------------------------------------------
	// Read path and unused bits
	// ----------------------------------------------------------------
	// Control read returns the stored byte
	ctrl_read_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		rd_ctrl_s |=> rdata == ($past(ctrl_r) & `CTRL_WMASK))
		else $error("control read wrong");
	// Unused control positions read zero
	ctrl_unused_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		rd_ctrl_s |=> (rdata & ~`CTRL_WMASK) == `RD_IDLE)
		else $error("control unused bits nonzero");
	// Level read returns the stored byte
	lvl_read_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		rd_lvl_s |=> rdata == ($past(lvl_r) & `LVL_WMASK))
		else $error("level read wrong");
	// Unused level positions read zero
	lvl_unused_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		rd_lvl_s |=> (rdata & ~`LVL_WMASK) == `RD_IDLE)
		else $error("level unused bits nonzero");
	// Unmapped index answers zero
	other_read_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		rd_other_s |=> rdata == `RD_IDLE)
		else $error("unmapped read nonzero");
	// Read data stand one cycle only
	rdata_idle_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!rd_stb |=> rdata == `RD_IDLE)
		else $error("read data outstayed");
	// Unused control positions never stored
	ctrl_masked_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ctrl_r & ~`CTRL_WMASK) == `RD_IDLE)
		else $error("control unused bit stored");
	// Unused level positions never stored
	lvl_masked_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		(lvl_r & ~`LVL_WMASK) == `RD_IDLE)
		else $error("level unused bit stored");
	// Unmapped write touches nothing
	other_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wr_other_s |=> $stable(ctrl_r) && $stable(lvl_r))
		else $error("unmapped write landed");

	// ----------------------------------------------------------------
	// Pad input gating
	// ----------------------------------------------------------------
	// Analog mode reads zero
	pin_read_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		pin_analog_mode |-> !pin_dig_in_gated)
		else $error("pin read not zero");
	// Digital mode passes the pad through
	pin_pass_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!pin_analog_mode |-> pin_dig_in_gated == pin_dig_in)
		else $error("pin read blocked");

endmodule // dac_ref_regs

`default_nettype wire

//--- dv/testbench.sv
/* Self-checking bench for the reference ladder control registers.
   Assumes the design package and its constants header on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "dac_ref_cfg.svh"
module testbench
	import dac_ref_pkg::*;
;
	// ------------------------------------------------------------
	// Signals and stimulus tables
	// ------------------------------------------------------------
	logic               clk_sys, rst, wr_stb, rd_stb, pin_dig_in;
	logic [`ADDR_W-1:0] addr;
	logic [7:0]         wdata, rdata;
	analog_t            analog;
	logic               pin_analog_mode, pin_dig_in_gated;
	logic [5:0]         level_num;
	int                 bad_count, n_compared;
	ctrl_t              c;    // Expected control contents
	logic [4:0]         lvl;  // Expected level code
	// Unused bits set on purpose; select code 11 never written
	logic [7:0] ctrl_vals [9] = '{8'h00, 8'h40, 8'h80, 8'h01, 8'h04, 8'h08, 8'h05, 8'h32, 8'hF7};
	logic [7:0] lvl_vals [4] = '{8'h1F, 8'hE5, 8'h00, 8'h10};

	dac_ref_regs u_dac_ref_regs (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .analog(analog),
		.pin_analog_mode(pin_analog_mode), .pin_dig_in_gated(pin_dig_in_gated),
		.pin_dig_in(pin_dig_in), .level_num(level_num));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Bus tasks and comparisons
	// ------------------------------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Leading edge wait keeps one gap, so a strobe is never set twice in a step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask

	// Data stand one cycle only, then drop to zero
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1 chk({4'h0, rdata}, {4'h0, exp});
		@(posedge clk_sys);
		#1 chk({4'h0, rdata}, 12'h000);
	endtask

	// Ladder drive as the control fields demand
	function automatic analog_t model(input ctrl_t k, input logic [4:0] v);
		analog_t m;
		m.converter_on = k.converter_on;
		m.upper_source_on = k.converter_on | k.low_power_source_pick;
		m.lower_source_on = k.converter_on | ~k.low_power_source_pick;
		m.sel_rail = (k.positive_source_select == SRC_RAIL);
		m.sel_ext = (k.positive_source_select == SRC_EXT);
		m.sel_fixed = (k.positive_source_select == SRC_FIXED);
		m.negative_source_select = k.negative_source_select;
		m.level_code = v;
		return m;
	endfunction

	// Pad input high except in the last check, so gating shows as a zero
	task automatic chk_pins;
		chk(analog, model(c, lvl));
		chk({6'h0, level_num}, {7'h0, lvl});
		chk({10'h0, pin_analog_mode, pin_dig_in_gated},
			{10'h0, c.pin_output_enable, pin_dig_in & ~c.pin_output_enable});
	endtask

	task automatic finish_test;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{wr_stb, rd_stb, addr, wdata} = '0;
		pin_dig_in = 1'b1;
		{bad_count, n_compared} = '0;
		{c, lvl} = '0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		chk_pins;
		foreach (ctrl_vals[i]) begin
			wr(4'h0, ctrl_vals[i]);
			c = ctrl_vals[i] & 8'hED;
			rd(4'h0, c);
			chk_pins;
		end
		foreach (lvl_vals[i]) begin
			wr(4'h1, lvl_vals[i]);
			lvl = lvl_vals[i][4:0];
			rd(4'h1, {3'h0, lvl});
			chk_pins;
		end
		// Unmapped index: write dropped, read zero
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'h00);
		rd(4'h0, c);
		// Reset in mid-run with every field set
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		{c, lvl} = '0;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		chk_pins;
		// Pad driven low passes through in digital mode
		pin_dig_in <= 1'b0;
		@(posedge clk_sys);
		#1 chk_pins;
		finish_test;
	end

	initial begin
		repeat (2000) @(posedge clk_sys);
		bad_count++;
		finish_test;
	end
endmodule // testbench
`default_nettype wire
